// ===== hdl/step_seq_pkg.sv
/*
 Shared constants and carrier types for the step sequence, latch and scan guard logic.
 Assumes a single 250 MHz clock domain and a scan executor that pulses scan start and scan end.
*/
package step_seq_pkg;
   localparam int CLOCK_MHZ = 250;
   localparam int SCAN_LIMIT_MS = 200;
   localparam int SCAN_EXTEND_MS = 200;
   localparam int LIMIT_CYCLES = SCAN_LIMIT_MS * 1000 * CLOCK_MHZ;
   localparam int EXTEND_CYCLES = SCAN_EXTEND_MS * 1000 * CLOCK_MHZ;
   localparam int STEP_COUNT = 64;
   localparam int STEP_INDEX_W = 6;
   localparam int GATE_COUNT = 11;
   localparam int OUT_COUNT = 4;
   localparam int EXTEND_OPERAND_W = 7;
   localparam logic [63:0] STEP_RESET = 64'h0;
   localparam logic LATCH_RESET = 1'b0;

   // one step-input gate on the current rung
   typedef struct packed {
      logic enable;
      logic rung_in;
      logic [STEP_INDEX_W-1:0] step;
   } gate_req_type;

   // one step-output action on the current rung
   typedef struct packed {
      logic enable;
      logic rung_in;
      logic [STEP_INDEX_W-1:0] step;
   } out_req_type;

   // step-chain initialisation request
   typedef struct packed {
      logic rung_in;
      logic [STEP_INDEX_W-1:0] start;
      logic [STEP_INDEX_W:0] size;
   } init_req_type;
endpackage

// ===== hdl/scan_guard.sv
/*
 Scan time-over detector with fixed extension.
 Assumes scan_start and scan_end are single-cycle pulses from same-clock logic.
*/
`timescale 1ns/1ps
module scan_guard #(
   parameter int LIMIT = step_seq_pkg::LIMIT_CYCLES,
   parameter int EXTEND = step_seq_pkg::EXTEND_CYCLES
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic scan_start,
   input wire logic scan_end,
   input wire logic extend_req,
   output logic time_over
);
   import step_seq_pkg::*;

   logic [31:0] count_reg;
   logic running_reg;
   logic extended_reg;
   logic time_over_reg;
   wire [31:0] limit_now = extended_reg ? 32'(LIMIT + EXTEND) : 32'(LIMIT);
   wire expired = running_reg && (count_reg >= limit_now);

   // extension is latched during the scan; operand is ignored upstream
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         count_reg <= 32'h0;
         running_reg <= 1'b0;
         extended_reg <= 1'b0;
      end else if (scan_start) begin
         count_reg <= 32'h0;
         running_reg <= 1'b1;
         extended_reg <= extend_req;
      end else begin
         if (scan_end || expired) begin
            running_reg <= 1'b0;
         end
         if (extend_req) begin
            extended_reg <= 1'b1;
         end
         count_reg <= count_reg + 32'h1;
      end
   end

   // sticky error, cleared at next scan start
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         time_over_reg <= 1'b0;
      end else if (expired && !scan_end) begin
         time_over_reg <= 1'b1;
      end else if (scan_start) begin
         time_over_reg <= 1'b0;
      end
   end

   assign time_over = time_over_reg;

   a_plain_limit: assert property (@(posedge clock) disable iff (rst)
      running_reg && !extended_reg && count_reg == 32'(LIMIT) && !scan_end && !scan_start |=> time_over_reg)
      else $error("time-over not flagged at plain limit");
   a_extend_holds: assert property (@(posedge clock) disable iff (rst)
      running_reg && extended_reg && count_reg < 32'(LIMIT + EXTEND) && !time_over_reg && !scan_start
      |=> !time_over_reg)
      else $error("time-over flagged inside extension");
endmodule

// ===== hdl/step_seq_core.sv
/*
 Step sequence chain, step gates and actions, reset-dominant latch, scan guard.
 Assumes rung inputs come from the scan executor on the same clock; rung_valid marks one evaluated rung.
*/
`timescale 1ns/1ps
module step_seq_core #(
   parameter int STEPS = step_seq_pkg::STEP_COUNT,
   parameter int GATES = step_seq_pkg::GATE_COUNT,
   parameter int OUTS = step_seq_pkg::OUT_COUNT,
   parameter int LIMIT = step_seq_pkg::LIMIT_CYCLES,
   parameter int EXTEND = step_seq_pkg::EXTEND_CYCLES
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic rung_valid,
   input step_seq_pkg::init_req_type init_req,
   input step_seq_pkg::gate_req_type [GATES-1:0] gate_req,
   input step_seq_pkg::out_req_type [OUTS-1:0] out_req,
   input wire logic latch_set,
   input wire logic latch_clear,
   input wire logic scan_start,
   input wire logic scan_end,
   input wire logic extend_in,
   input wire logic [step_seq_pkg::EXTEND_OPERAND_W-1:0] extend_operand,
   output logic [STEPS-1:0] steps,
   output logic [GATES-1:0] gate_out,
   output logic init_out,
   output logic extend_out,
   output logic latch_out,
   output logic time_over
);
   import step_seq_pkg::*;

   typedef enum logic [1:0] {
      INIT_IDLE = 2'b00,
      INIT_HELD = 2'b01
   } init_state_type;

   logic [STEPS-1:0] steps_reg;
   logic [STEPS-1:0] steps_next;
   logic [GATES-1:0] gate_out_reg;
   logic init_out_reg;
   logic extend_out_reg;
   logic latch_reg;
   logic latch_next;
   init_state_type init_state_reg;
   init_state_type init_state_next;

   // mask of n consecutive steps from start, wrapping past the top is dropped
   function automatic logic [STEPS-1:0] range_mask(input logic [STEP_INDEX_W-1:0] start,
                                                  input logic [STEP_INDEX_W:0] size);
      logic [STEPS-1:0] m;
      m = '0;
      for (int i = 0; i < STEPS; i++) begin
         if (i >= int'(start) && i < int'(start) + int'(size)) begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction

   // one-hot decode of a step index
   function automatic logic [STEPS-1:0] one_hot(input logic [STEP_INDEX_W-1:0] idx);
      logic [STEPS-1:0] m;
      m = '0;
      m[idx] = 1'b1;
      return m;
   endfunction

   // rising edge detect of the initialisation rung input
   wire init_active = rung_valid && init_req.rung_in;
   wire init_edge = init_active && (init_state_reg == INIT_IDLE);
   wire init_size_ok = (init_req.size != '0) && (init_req.size <= 7'(STEPS));

   // gate results and any step action on this rung
   logic [GATES-1:0] gate_hit;
   logic [STEPS-1:0] gate_clear_mask;
   logic [STEPS-1:0] out_set_mask;
   logic any_out;
   always_comb begin
      gate_hit = '0;
      gate_clear_mask = '0;
      out_set_mask = '0;
      any_out = 1'b0;
      for (int g = 0; g < GATES; g++) begin
         gate_hit[g] = gate_req[g].enable && gate_req[g].rung_in && steps_reg[gate_req[g].step];
         if (gate_req[g].enable) begin
            gate_clear_mask = gate_clear_mask | one_hot(gate_req[g].step);
         end
      end
      for (int o = 0; o < OUTS; o++) begin
         if (out_req[o].enable && out_req[o].rung_in) begin
            out_set_mask = out_set_mask | one_hot(out_req[o].step);
            any_out = 1'b1;
         end
      end
   end

   // next step flags: init first, then action clears then sets
   always_comb begin
      steps_next = steps_reg;
      if (rung_valid && init_edge && init_size_ok) begin
         steps_next = (steps_reg & ~range_mask(init_req.start, init_req.size)) | one_hot(init_req.start);
      end else if (rung_valid && any_out) begin
         steps_next = (steps_reg & ~gate_clear_mask) | out_set_mask;
      end
   end

   // reset-dominant latch
   always_comb begin
      latch_next = latch_reg;
      if (rung_valid && latch_clear) begin
         latch_next = 1'b0;
      end else if (rung_valid && latch_set) begin
         latch_next = 1'b1;
      end
   end

   // init edge state follows the rung input on every evaluated rung
   always_comb begin
      init_state_next = init_state_reg;
      if (rung_valid) begin
         init_state_next = init_req.rung_in ? INIT_HELD : INIT_IDLE;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         steps_reg <= STEP_RESET[STEPS-1:0];
         latch_reg <= LATCH_RESET;
         init_state_reg <= INIT_IDLE;
      end else begin
         steps_reg <= steps_next;
         latch_reg <= latch_next;
         init_state_reg <= init_state_next;
      end
   end

   // rung outputs registered once per evaluated rung
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         gate_out_reg <= '0;
         init_out_reg <= 1'b0;
         extend_out_reg <= 1'b0;
      end else if (rung_valid) begin
         gate_out_reg <= gate_hit;
         init_out_reg <= init_req.rung_in;
         extend_out_reg <= extend_in;
      end
   end

   // operand is accepted but has no effect on the extension
   wire extend_req = rung_valid && extend_in && (extend_operand == extend_operand);

   scan_guard #(
      .LIMIT(LIMIT),
      .EXTEND(EXTEND)
   ) guard (
      .clock(clock),
      .rst(rst),
      .scan_start(scan_start),
      .scan_end(scan_end),
      .extend_req(extend_req),
      .time_over(time_over)
   );

   assign steps = steps_reg;
   assign gate_out = gate_out_reg;
   assign init_out = init_out_reg;
   assign extend_out = extend_out_reg;
   assign latch_out = latch_reg;

   sequence s_init_rise;
      rung_valid && init_req.rung_in && init_state_reg == INIT_IDLE && init_size_ok;
   endsequence

   // input held on and no action on the rung: the chain must not move
   sequence s_init_held;
      rung_valid && init_req.rung_in && init_state_reg == INIT_HELD && !any_out;
   endsequence

   a_init_sets_start: assert property (@(posedge clock) disable iff (rst)
      s_init_rise |=> steps_reg[$past(init_req.start)])
      else $error("start flag not set on init");
   a_init_no_repeat: assert property (@(posedge clock) disable iff (rst)
      s_init_held |=> steps_reg == $past(steps_reg))
      else $error("chain reinitialised while held");
   a_gate_and: assert property (@(posedge clock) disable iff (rst)
      rung_valid && gate_req[0].enable |=> gate_out_reg[0] == $past(gate_req[0].rung_in && steps_reg[gate_req[0].step]))
      else $error("step gate output wrong");
   a_action_sets: assert property (@(posedge clock) disable iff (rst)
      rung_valid && !init_edge && out_req[0].enable && out_req[0].rung_in |=> steps_reg[$past(out_req[0].step)])
      else $error("action target not set");
   a_action_clears: assert property (@(posedge clock) disable iff (rst)
      rung_valid && !init_edge && any_out |=> (steps_reg & $past(gate_clear_mask & ~out_set_mask)) == '0)
      else $error("gated flags not cleared by action");
   a_action_parallel: assert property (@(posedge clock) disable iff (rst)
      rung_valid && !init_edge && any_out |=> (steps_reg & $past(out_set_mask)) == $past(out_set_mask))
      else $error("parallel targets not all set");
   a_latch_reset_wins: assert property (@(posedge clock) disable iff (rst)
      rung_valid && latch_clear |=> !latch_out)
      else $error("latch not cleared by reset");
   a_latch_hold: assert property (@(posedge clock) disable iff (rst)
      !(rung_valid && (latch_set || latch_clear)) |=> $stable(latch_out))
      else $error("latch changed without input");
   a_rung_follow: assert property (@(posedge clock) disable iff (rst)
      rung_valid |=> extend_out == $past(extend_in) && init_out == $past(init_req.rung_in))
      else $error("rung output does not follow input");
endmodule

// ===== tb/scan_exec.sv
/*
 Model of the scan executor's framing: a scan start pulse, the scan body, a scan end pulse.
 Assumes the bench clock; the bench commands each scan and its length through run.
*/
`timescale 1ns/1ps
module scan_exec (
   input wire logic clock,
   input wire logic rst,
   output logic scan_start,
   output logic scan_end
);
   // one scan of len cycles, framed by single-cycle pulses; long len models a slow scan
   // main program only: no interrupt return ever ends a scan; no scan while in reset
   task automatic run(input int len);
      wait (!rst);
      @(posedge clock);
      scan_start <= 1'b1;
      @(posedge clock);
      scan_start <= 1'b0;
      repeat (len) @(posedge clock);
      scan_end <= 1'b1;
      @(posedge clock);
      scan_end <= 1'b0;
   endtask

   // both pulses idle low from time zero
   initial begin
      scan_start = 1'b0;
      scan_end = 1'b0;
   end
endmodule

// ===== tb/test_step_sequence_flipflop_scan_guard.sv
/*
 Self-checking bench for the step chain, step gates and actions, latch and scan guard.
 Assumes the core with shortened scan limits and the scan executor model beside it.
*/
`timescale 1ns/1ps
module test_step_sequence_flipflop_scan_guard;
   import step_seq_pkg::*;
   logic clock, rst, rung_valid, latch_set, latch_clear, extend_in, scan_start, scan_end;
   logic init_out, extend_out, latch_out, time_over;
   logic [6:0] extend_operand;
   logic [63:0] steps, exp_steps;
   logic [10:0] gate_out;
   init_req_type init_req;
   gate_req_type [10:0] gate_req;
   out_req_type [3:0] out_req;
   int n_errors, n_checks;

   step_seq_core #(.LIMIT(20), .EXTEND(20)) step_seq_core_i (.clock(clock), .rst(rst),
      .rung_valid(rung_valid), .init_req(init_req), .gate_req(gate_req), .out_req(out_req),
      .latch_set(latch_set), .latch_clear(latch_clear), .scan_start(scan_start),
      .scan_end(scan_end), .extend_in(extend_in), .extend_operand(extend_operand),
      .steps(steps), .gate_out(gate_out), .init_out(init_out), .extend_out(extend_out),
      .latch_out(latch_out), .time_over(time_over));
   scan_exec scan_exec_i (.clock(clock), .rst(rst), .scan_start(scan_start), .scan_end(scan_end));

   // compare and count
   task automatic check(input logic [63:0] seen, input logic [63:0] expected);
      n_checks++;
      if (seen !== expected) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, expected);
      end
   endtask

   // present one rung at the next edge, then drop rung_valid and the gate and action requests
   task automatic fire();
      rung_valid <= 1'b1;
      @(posedge clock);
      rung_valid <= 1'b0;
      gate_req <= '0;
      out_req <= '0;
      #1;
   endtask

   // chain initialisation, its edge sensitivity and its output
   task automatic t_init();
      @(posedge clock);
      init_req <= '{1'b1, 6'h05, 7'h0a};
      fire();
      exp_steps = 64'h20;
      check(steps, exp_steps);
      check(64'(init_out), 64'h1);
      @(posedge clock);
      for (int o = 0; o < 2; o++) begin
         out_req[o] <= '{1'b1, 1'b1, 6'(14 + o)};
      end
      fire();
      exp_steps = 64'h0000_0000_0000_c020;
      check(steps, exp_steps);
      @(posedge clock);
      init_req.rung_in <= 1'b0;
      fire();
      check(64'(init_out), 64'h0);
      @(posedge clock);
      init_req.rung_in <= 1'b1;
      fire();
      exp_steps = 64'h0000_0000_0000_8020;
      check(steps, exp_steps);
   endtask

   // gates test flags; actions set targets and clear every gated flag; parallel gates and actions share the second rung
   task automatic t_step();
      @(posedge clock);
      gate_req[0] <= '{1'b1, 1'b1, 6'h05};
      gate_req[1] <= '{1'b1, 1'b1, 6'h06};
      gate_req[2] <= '{1'b1, 1'b0, 6'h0f};
      fire();
      check(64'(gate_out[2:0]), 64'h1);
      check(steps, exp_steps);
      @(posedge clock);
      for (int i = 0; i < 11; i++) begin
         gate_req[i] <= '{1'b1, 1'b1, 6'(i + 5)};
      end
      for (int o = 0; o < 3; o++) begin
         out_req[o] <= '{1'b1, 1'(o < 2), 6'(20 + 10 * o)};
      end
      fire();
      exp_steps = 64'h0000_0000_4010_0000;
      check(steps, exp_steps);
      check(64'(gate_out), 64'h401);
   endtask

   // reset-dominant latch; entries are set, clear, expected flag; set and clear come straight from the table
   task automatic t_latch();
      logic [2:0] tbl [6];
      tbl = '{3'b101, 3'b001, 3'b110, 3'b101, 3'b010, 3'b000};
      for (int i = 0; i < 6; i++) begin
         @(posedge clock);
         latch_set <= tbl[i][2];
         latch_clear <= tbl[i][1];
         fire();
         check(64'(latch_out), 64'(tbl[i][0]));
      end
   endtask

   // extension rung some cycles into a scan, operand value as given
   task automatic extend_rung(input logic [6:0] operand);
      repeat (3) @(posedge clock);
      extend_in <= 1'b1;
      extend_operand <= operand;
      fire();
      check(64'(extend_out), 64'h1);
      @(posedge clock);
      extend_in <= 1'b0;
      fire();
      check(64'(extend_out), 64'h0);
   endtask

   // scan time-over with and without the fixed extension, one cycle either side of each limit
   task automatic t_scan();
      scan_exec_i.run(19);
      check(64'(time_over), 64'h0);
      scan_exec_i.run(21);
      check(64'(time_over), 64'h1);
      fork
         scan_exec_i.run(39);
         extend_rung(7'h64);
      join
      check(64'(time_over), 64'h0);
      fork
         scan_exec_i.run(41);
         extend_rung(7'h01);
      join
      check(64'(time_over), 64'h1);
   endtask

   // print the counts and the verdict, then end the run
   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // 250 MHz clock
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // cut a hang short well past the expected run length
   initial begin
      #20000;
      n_errors++;
      stop_test();
   end

   // reset, then the scenarios in turn
   initial begin
      n_errors = 0;
      n_checks = 0;
      rst = 1'b1;
      rung_valid = 1'b0;
      latch_set = 1'b0;
      latch_clear = 1'b0;
      extend_in = 1'b0;
      extend_operand = 7'h01;
      init_req = '0;
      gate_req = '0;
      out_req = '0;
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      t_init();
      t_step();
      t_latch();
      t_scan();
      stop_test();
   end
endmodule
